// File: dots_output_stage.sv
/*
 * ddc output stage: latency alignment code, wideband and narrowband gain,
 * and per-stream test pattern generation for two ddcs.
 * assumes a byte-wide register port synchronous to SYS_CLK, samples
 * arriving with SAMPLE_VALID, and the decimation mode given by WIDEBAND_PATH.
 */
//
// Contract
// - latency alignment code sits in bits 6 to 4 and is driven out.
// - wideband gain bit doubles wide filter path output, only in divide-by-4/6.
// - two 16-bit user words held in byte registers 33h to 36h.
// - per-stream 4-bit selectors; 0 normal, 1 zeros, 2 ones.
// - code 3 alternates 1010 word and its complement each sample.
// - code 4 outputs ramp from 0 to 65535 by one, then wraps.
// - code 6 sends user word 1; code 7 alternates words 1 and 2.
// - code 8 sends all-ones deskew word; code 9 sends sync word.
// - scope bit 0 makes all streams use low nibble of 37h.
// - narrowband gain does not act on the wideband path.
//
`timescale 1ns/1ps
module dots_output_stage
	import dots_pkg::*;
(
	input  wire logic        SYS_CLK,         // 100 MHz sample-side clock
	input  wire logic        RST,             // async reset, high
	input  wire logic        REG_WE,          // register write strobe
	input  wire logic        REG_RE,          // register read strobe
	input  wire logic [7:0]  REG_ADDR,        // register offset
	input  wire logic [7:0]  REG_WDATA,       // write data
	output logic      [7:0]  REG_RDATA,       // read data, one cycle after REG_RE
	input  wire logic        WIDEBAND_PATH,   // divide-by-4 or -6 active
	input  wire logic        NARROWBAND_GAIN, // narrowband_double_gain for first ddc
	input  wire logic        SAMPLE_VALID,    // new sample on inputs
	input  wire logic [15:0] FIRST_I_IN,      // first ddc i sample
	input  wire logic [15:0] FIRST_Q_IN,      // first ddc q sample
	input  wire logic [15:0] SECOND_I_IN,     // second ddc i sample
	input  wire logic [15:0] SECOND_Q_IN,     // second ddc q sample
	output logic      [15:0] FIRST_I_OUT,     // first ddc i output
	output logic      [15:0] FIRST_Q_OUT,     // first ddc q output
	output logic      [15:0] SECOND_I_OUT,    // second ddc i output
	output logic      [15:0] SECOND_Q_OUT,    // second ddc q output
	output logic             OUT_VALID,       // outputs updated
	output logic      [2:0]  LAT_CODE         // latency_align_code
);
	logic [2:0]  latency_align_cfg_ff;
	logic        wideband_gain_cfg_ff;
	logic [15:0] user_word1_ff;
	logic [15:0] user_word2_ff;
	logic [7:0]  first_ddc_pattern_sel_ff;
	logic [7:0]  second_ddc_pattern_sel_ff;
	logic        pattern_scope_cfg_ff;
	logic        pattern_restart_allow_ff;
	logic        pattern_restart_pulse_ff;
	logic        nxt_restart_pulse;
	logic [7:0]  rdata_ff;
	logic [7:0]  nxt_rdata;
	logic        valid_ff;

	// ---------------------------------------------------------------
	// register decode
	// ---------------------------------------------------------------
	logic wr_lat, wr_wbg, wr_w1l, wr_w1h, wr_w2l, wr_w2h, wr_s1, wr_s2, wr_scope, wr_rst;
	assign wr_lat   = REG_WE && REG_ADDR == ADDR_LATENCY_ALIGN;
	assign wr_wbg   = REG_WE && REG_ADDR == ADDR_WIDEBAND_GAIN;
	assign wr_w1l   = REG_WE && REG_ADDR == ADDR_USER_W1_LOW;
	assign wr_w1h   = REG_WE && REG_ADDR == ADDR_USER_W1_HIGH;
	assign wr_w2l   = REG_WE && REG_ADDR == ADDR_USER_W2_LOW;
	assign wr_w2h   = REG_WE && REG_ADDR == ADDR_USER_W2_HIGH;
	assign wr_s1    = REG_WE && REG_ADDR == ADDR_FIRST_SEL;
	assign wr_s2    = REG_WE && REG_ADDR == ADDR_SECOND_SEL;
	assign wr_scope = REG_WE && REG_ADDR == ADDR_SCOPE;
	assign wr_rst   = REG_WE && REG_ADDR == ADDR_RESTART;

	// restart only honoured when allow was set by an earlier write
	assign nxt_restart_pulse = wr_rst && REG_WDATA[PULSE_BIT] && pattern_restart_allow_ff;

	// read mux: reserved bits read zero, unmapped offsets read zero
	assign nxt_rdata = !REG_RE ? rdata_ff :
	                   (REG_ADDR == ADDR_LATENCY_ALIGN) ? {1'b0, latency_align_cfg_ff, 4'h0} :
	                   (REG_ADDR == ADDR_WIDEBAND_GAIN) ? {7'h00, wideband_gain_cfg_ff} :
	                   (REG_ADDR == ADDR_USER_W1_LOW)   ? user_word1_ff[7:0] :
	                   (REG_ADDR == ADDR_USER_W1_HIGH)  ? user_word1_ff[15:8] :
	                   (REG_ADDR == ADDR_USER_W2_LOW)   ? user_word2_ff[7:0] :
	                   (REG_ADDR == ADDR_USER_W2_HIGH)  ? user_word2_ff[15:8] :
	                   (REG_ADDR == ADDR_FIRST_SEL)     ? first_ddc_pattern_sel_ff :
	                   (REG_ADDR == ADDR_SECOND_SEL)    ? second_ddc_pattern_sel_ff :
	                   (REG_ADDR == ADDR_SCOPE)         ? {7'h00, pattern_scope_cfg_ff} :
	                   (REG_ADDR == ADDR_RESTART)       ? {7'h00, pattern_restart_allow_ff} :
	                   RST_BYTE;

	// configuration registers; reserved write bits are dropped
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			latency_align_cfg_ff      <= RST_LAT;
			wideband_gain_cfg_ff      <= RST_BIT;
			user_word1_ff             <= RST_WORD;
			user_word2_ff             <= RST_WORD;
			first_ddc_pattern_sel_ff  <= RST_BYTE;
			second_ddc_pattern_sel_ff <= RST_BYTE;
			pattern_scope_cfg_ff      <= RST_BIT;
			pattern_restart_allow_ff  <= RST_BIT;
		end else begin
			if (wr_lat) latency_align_cfg_ff <= REG_WDATA[LAT_MSB:LAT_LSB];
			if (wr_wbg) wideband_gain_cfg_ff <= REG_WDATA[WBG_BIT];
			if (wr_w1l) user_word1_ff[7:0] <= REG_WDATA;
			if (wr_w1h) user_word1_ff[15:8] <= REG_WDATA;
			if (wr_w2l) user_word2_ff[7:0] <= REG_WDATA;
			if (wr_w2h) user_word2_ff[15:8] <= REG_WDATA;
			if (wr_s1) first_ddc_pattern_sel_ff <= REG_WDATA;
			if (wr_s2) second_ddc_pattern_sel_ff <= REG_WDATA;
			if (wr_scope) pattern_scope_cfg_ff <= REG_WDATA[SCOPE_BIT];
			if (wr_rst) pattern_restart_allow_ff <= REG_WDATA[ALLOW_BIT];
		end
	end

	// restart pulse, read data and sample valid
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pattern_restart_pulse_ff <= RST_BIT;
			rdata_ff                 <= RST_BYTE;
			valid_ff                 <= RST_BIT;
		end else begin
			pattern_restart_pulse_ff <= nxt_restart_pulse;
			rdata_ff                 <= nxt_rdata;
			valid_ff                 <= SAMPLE_VALID;
		end
	end

	assign REG_RDATA = rdata_ff;
	assign OUT_VALID = valid_ff;
	assign LAT_CODE  = latency_align_cfg_ff;

	// ---------------------------------------------------------------
	// gain stage
	// ---------------------------------------------------------------
	// doubling saturates instead of wrapping at full scale
	function automatic logic [15:0] sat_double(input logic [15:0] x);
		if (x[15] != x[14]) begin
			sat_double = x[15] ? WORD_NEG_MAX : WORD_POS_MAX;
		end else begin
			sat_double = {x[14:0], 1'b0};
		end
	endfunction

	logic gain_first, gain_second;
	logic [15:0] first_i_g, first_q_g, second_i_g, second_q_g;
	// wideband bit only on the wide path, narrowband bit never there
	assign gain_first  = WIDEBAND_PATH ? wideband_gain_cfg_ff : NARROWBAND_GAIN;
	assign gain_second = WIDEBAND_PATH && wideband_gain_cfg_ff;
	assign first_i_g   = gain_first ? sat_double(FIRST_I_IN) : FIRST_I_IN;
	assign first_q_g   = gain_first ? sat_double(FIRST_Q_IN) : FIRST_Q_IN;
	assign second_i_g  = gain_second ? sat_double(SECOND_I_IN) : SECOND_I_IN;
	assign second_q_g  = gain_second ? sat_double(SECOND_Q_IN) : SECOND_Q_IN;

	// ---------------------------------------------------------------
	// pattern lanes
	// ---------------------------------------------------------------
	logic [3:0] sel_fi, sel_fq, sel_si, sel_sq;
	// common mode: every stream follows the low nibble of the first selector
	assign sel_fi = first_ddc_pattern_sel_ff[3:0];
	assign sel_fq = pattern_scope_cfg_ff ? first_ddc_pattern_sel_ff[7:4] : first_ddc_pattern_sel_ff[3:0];
	assign sel_si = pattern_scope_cfg_ff ? second_ddc_pattern_sel_ff[3:0] : first_ddc_pattern_sel_ff[3:0];
	assign sel_sq = pattern_scope_cfg_ff ? second_ddc_pattern_sel_ff[7:4] : first_ddc_pattern_sel_ff[3:0];

	dots_pattern_lane u_first_i (.clk(SYS_CLK), .rst(RST), .sel(sel_fi), .step(SAMPLE_VALID),
		.restart(pattern_restart_pulse_ff), .din(first_i_g), .word1(user_word1_ff),
		.word2(user_word2_ff), .dout(FIRST_I_OUT));
	dots_pattern_lane u_first_q (.clk(SYS_CLK), .rst(RST), .sel(sel_fq), .step(SAMPLE_VALID),
		.restart(pattern_restart_pulse_ff), .din(first_q_g), .word1(user_word1_ff),
		.word2(user_word2_ff), .dout(FIRST_Q_OUT));
	dots_pattern_lane u_second_i (.clk(SYS_CLK), .rst(RST), .sel(sel_si), .step(SAMPLE_VALID),
		.restart(pattern_restart_pulse_ff), .din(second_i_g), .word1(user_word1_ff),
		.word2(user_word2_ff), .dout(SECOND_I_OUT));
	dots_pattern_lane u_second_q (.clk(SYS_CLK), .rst(RST), .sel(sel_sq), .step(SAMPLE_VALID),
		.restart(pattern_restart_pulse_ff), .din(second_q_g), .word1(user_word1_ff),
		.word2(user_word2_ff), .dout(SECOND_Q_OUT));

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_lat_code;
		@(posedge SYS_CLK) disable iff (RST) wr_lat |=> LAT_CODE == $past(REG_WDATA[6:4]);
	endproperty
	a_lat_code: assert property (p_lat_code) else $error("latency code not taken from bits 6-4");

	property p_restart_gate;
		@(posedge SYS_CLK) disable iff (RST)
			(wr_rst && REG_WDATA[1] && !pattern_restart_allow_ff) |=> !pattern_restart_pulse_ff;
	endproperty
	a_restart_gate: assert property (p_restart_gate) else $error("restart without allow");

	property p_wide_gain;
		@(posedge SYS_CLK) disable iff (RST)
			(SAMPLE_VALID && WIDEBAND_PATH && wideband_gain_cfg_ff && sel_si == 4'h0
			 && SECOND_I_IN[15] == SECOND_I_IN[14])
			|=> SECOND_I_OUT == {$past(SECOND_I_IN[14:0]), 1'b0};
	endproperty
	a_wide_gain: assert property (p_wide_gain) else $error("wideband gain not applied");

	property p_narrow_blocked;
		@(posedge SYS_CLK) disable iff (RST)
			(SAMPLE_VALID && WIDEBAND_PATH && !wideband_gain_cfg_ff && sel_fi == 4'h0)
			|=> FIRST_I_OUT == $past(FIRST_I_IN);
	endproperty
	a_narrow_blocked: assert property (p_narrow_blocked) else $error("narrowband gain on wide path");

	property p_common;
		@(posedge SYS_CLK) disable iff (RST)
			(SAMPLE_VALID && !pattern_scope_cfg_ff && first_ddc_pattern_sel_ff[3:0] == 4'h1)
			|=> SECOND_Q_OUT == 16'h0000 && FIRST_Q_OUT == 16'h0000;
	endproperty
	a_common: assert property (p_common) else $error("common pattern not shared");

	property p_word_read;
		@(posedge SYS_CLK) disable iff (RST)
			wr_w2h ##2 (REG_RE && REG_ADDR == 8'h36 && !REG_WE) |=> REG_RDATA == $past(REG_WDATA, 3);
	endproperty
	a_word_read: assert property (p_word_read) else $error("user word high byte readback wrong");
endmodule

// File: dots_pattern_lane.sv
/*
 * one output lane: replaces a sample stream with the selected test pattern.
 * assumes step marks a new sample and restart is a one-cycle pulse.
 */
`timescale 1ns/1ps
module dots_pattern_lane
	import dots_pkg::*;
(
	input  wire logic        clk,     // sample clock
	input  wire logic        rst,     // async reset, high
	input  wire logic [3:0]  sel,     // pattern selector
	input  wire logic        step,    // new sample
	input  wire logic        restart, // restart pattern sequence
	input  wire logic [15:0] din,     // converter data after gain
	input  wire logic [15:0] word1,   // user pattern word 1
	input  wire logic [15:0] word2,   // user pattern word 2
	output logic      [15:0] dout     // lane output
);
	logic [15:0] ramp_ff;
	logic [15:0] nxt_ramp;
	logic        phase_ff;
	logic        nxt_phase;
	logic [15:0] dout_ff;
	logic [15:0] nxt_dout;
	logic [15:0] pat_word;

	// ---------------------------------------------------------------
	// pattern selection
	// ---------------------------------------------------------------
	// unlisted codes fall through to converter data
	assign pat_word = (sel == PAT_ZEROS)  ? WORD_ZEROS :
	                  (sel == PAT_ONES)   ? WORD_ONES :
	                  (sel == PAT_TOGGLE) ? (phase_ff ? WORD_TOGGLE_B : WORD_TOGGLE_A) :
	                  (sel == PAT_RAMP)   ? ramp_ff :
	                  (sel == PAT_SINGLE) ? word1 :
	                  (sel == PAT_DOUBLE) ? (phase_ff ? word2 : word1) :
	                  (sel == PAT_DESKEW) ? WORD_DESKEW :
	                  (sel == PAT_SYNC)   ? WORD_SYNC :
	                  din;

	// ramp wraps naturally after 65535; restart returns sequences to start
	assign nxt_ramp  = restart ? RST_WORD : (step ? ramp_ff + RAMP_STEP : ramp_ff);
	assign nxt_phase = restart ? RST_BIT : (step ? ~phase_ff : phase_ff);
	assign nxt_dout  = step ? pat_word : dout_ff;
	assign dout      = dout_ff;

	// sequence state and output register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ramp_ff  <= RST_WORD;
			phase_ff <= RST_BIT;
			dout_ff  <= RST_WORD;
		end else begin
			ramp_ff  <= nxt_ramp;
			phase_ff <= nxt_phase;
			dout_ff  <= nxt_dout;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_zeros;
		@(posedge clk) disable iff (rst) (step && sel == PAT_ZEROS) |=> dout == 16'h0000;
	endproperty
	a_zeros: assert property (p_zeros) else $error("zeros pattern wrong");

	property p_ones;
		@(posedge clk) disable iff (rst) (step && sel == PAT_ONES) |=> dout == 16'hffff;
	endproperty
	a_ones: assert property (p_ones) else $error("ones pattern wrong");

	property p_toggle;
		@(posedge clk) disable iff (rst)
			(step && sel == PAT_TOGGLE && !restart) ##1 (step && sel == PAT_TOGGLE)
			|=> dout == ~$past(dout);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle pattern does not alternate");

	property p_ramp;
		@(posedge clk) disable iff (rst)
			(step && sel == PAT_RAMP && !restart) ##1 (step && sel == PAT_RAMP && !restart)
			|=> dout == $past(dout) + 16'h0001;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp did not step by one");

	property p_restart;
		@(posedge clk) disable iff (rst)
			restart ##1 (step && sel == PAT_RAMP && !restart) |=> dout == 16'h0000;
	endproperty
	a_restart: assert property (p_restart) else $error("ramp not restarted at zero");

	property p_single;
		@(posedge clk) disable iff (rst) (step && sel == PAT_SINGLE) |=> dout == $past(word1);
	endproperty
	a_single: assert property (p_single) else $error("single user word wrong");

	property p_double;
		@(posedge clk) disable iff (rst)
			restart ##1 (step && sel == PAT_DOUBLE && !restart) |=> dout == $past(word1);
	endproperty
	a_double: assert property (p_double) else $error("double pattern does not start on word 1");

	property p_deskew;
		@(posedge clk) disable iff (rst) (step && sel == PAT_DESKEW) |=> dout == 16'hffff;
	endproperty
	a_deskew: assert property (p_deskew) else $error("deskew word wrong");

	property p_normal;
		@(posedge clk) disable iff (rst)
			(step && (sel == PAT_NORMAL || sel == 4'h5 || sel >= 4'ha)) |=> dout == $past(din);
	endproperty
	a_normal: assert property (p_normal) else $error("converter data not passed");
endmodule

// File: dots_pkg.sv
/*
 * constants for the ddc output stage: register offsets, field positions,
 * reset values and test pattern codes.
 * assumes an 8-bit paged register port and 16-bit i/q samples.
 */
package dots_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_LATENCY_ALIGN  = 8'h1e;
	localparam logic [7:0] ADDR_WIDEBAND_GAIN  = 8'h1f;
	localparam logic [7:0] ADDR_USER_W1_LOW    = 8'h33;
	localparam logic [7:0] ADDR_USER_W1_HIGH   = 8'h34;
	localparam logic [7:0] ADDR_USER_W2_LOW    = 8'h35;
	localparam logic [7:0] ADDR_USER_W2_HIGH   = 8'h36;
	localparam logic [7:0] ADDR_FIRST_SEL      = 8'h37;
	localparam logic [7:0] ADDR_SECOND_SEL     = 8'h38;
	localparam logic [7:0] ADDR_SCOPE          = 8'h39;
	localparam logic [7:0] ADDR_RESTART        = 8'h3a;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int         LAT_LSB             = 4;
	localparam int         LAT_MSB             = 6;
	localparam int         WBG_BIT             = 0;
	localparam int         SCOPE_BIT           = 0;
	localparam int         ALLOW_BIT           = 0;
	localparam int         PULSE_BIT           = 1;
	localparam logic [7:0] RST_BYTE            = 8'h00;
	localparam logic [2:0] RST_LAT             = 3'h0;
	localparam logic       RST_BIT             = 1'b0;
	localparam logic [15:0] RST_WORD           = 16'h0000;

	// ---------------------------------------------------------------
	// pattern selector codes and fixed words
	// ---------------------------------------------------------------
	localparam logic [3:0] PAT_NORMAL          = 4'h0;
	localparam logic [3:0] PAT_ZEROS           = 4'h1;
	localparam logic [3:0] PAT_ONES            = 4'h2;
	localparam logic [3:0] PAT_TOGGLE          = 4'h3;
	localparam logic [3:0] PAT_RAMP            = 4'h4;
	localparam logic [3:0] PAT_SINGLE          = 4'h6;
	localparam logic [3:0] PAT_DOUBLE          = 4'h7;
	localparam logic [3:0] PAT_DESKEW          = 4'h8;
	localparam logic [3:0] PAT_SYNC            = 4'h9;
	localparam logic [15:0] WORD_ZEROS         = 16'h0000;
	localparam logic [15:0] WORD_ONES          = 16'hffff;
	localparam logic [15:0] WORD_TOGGLE_A      = 16'haaaa;
	localparam logic [15:0] WORD_TOGGLE_B      = 16'h5555;
	localparam logic [15:0] WORD_DESKEW        = 16'hffff;
	localparam logic [15:0] WORD_SYNC          = 16'h0000; // arbitrary value
	localparam logic [15:0] WORD_POS_MAX       = 16'h7fff;
	localparam logic [15:0] WORD_NEG_MAX       = 16'h8000;
	localparam logic [15:0] RAMP_STEP          = 16'h0001;
endpackage

// File: dots_sink.sv
/*
 * downstream link-side model: takes each sample set that the stage marks valid.
 * assumes one OUT_VALID pulse per sample set, on the stage's own clock.
 */
`timescale 1ns/1ps
module dots_sink (
	input  wire logic        clk,   // sample clock
	input  wire logic        rst,   // async reset, high
	input  wire logic        valid, // output sample strobe
	input  wire logic [15:0] i0,    // first ddc i
	input  wire logic [15:0] i1,    // first ddc q
	input  wire logic [15:0] i2,    // second ddc i
	input  wire logic [15:0] i3,    // second ddc q
	output logic      [15:0] s0,    // taken first ddc i
	output logic      [15:0] s1,    // taken first ddc q
	output logic      [15:0] s2,    // taken second ddc i
	output logic      [15:0] s3,    // taken second ddc q
	output logic      [15:0] cnt    // sample sets taken
);
	// capture on each strobe; nothing moves between strobes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s0 <= 16'h0000;
			s1 <= 16'h0000;
			s2 <= 16'h0000;
			s3 <= 16'h0000;
			cnt <= 16'h0000;
		end else if (valid) begin
			s0 <= i0;
			s1 <= i1;
			s2 <= i2;
			s3 <= i3;
			cnt <= cnt + 16'h0001;
		end
	end
endmodule

// File: test_dots_output_stage.sv
/*
 * self-checking bench for the ddc output stage: registers, patterns, restart, gain.
 * assumes dots_pkg and the dots_sink model on the sample outputs.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module test_dots_output_stage
	import dots_pkg::*;
;
	logic        clk, rst, we, re, wb, nb, sv, ph;
	logic [7:0]  addr, wd, rdata;
	logic [2:0]  lat;
	logic [15:0] din [4];
	logic [15:0] snk [4];
	logic [15:0] rmp, cnt;
	int          bad_count, n_checks, nsm;
	logic [7:0]  ra [11] = '{8'h1e, 8'h1f, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h20};
	logic [7:0]  lc [4] = '{8'h10, 8'h20, 8'h40, 8'h50};
	logic [7:0]  uw [4] = '{8'h34, 8'h12, 8'h78, 8'h56};

	dots_output_stage dut (.SYS_CLK(clk), .RST(rst), .REG_WE(we), .REG_RE(re), .REG_ADDR(addr),
		.REG_WDATA(wd), .REG_RDATA(rdata), .WIDEBAND_PATH(wb), .NARROWBAND_GAIN(nb),
		.SAMPLE_VALID(sv), .FIRST_I_IN(din[0]), .FIRST_Q_IN(din[1]), .SECOND_I_IN(din[2]),
		.SECOND_Q_IN(din[3]), .FIRST_I_OUT(), .FIRST_Q_OUT(), .SECOND_I_OUT(), .SECOND_Q_OUT(),
		.OUT_VALID(), .LAT_CODE(lat));
	dots_sink u_sink (.clk(clk), .rst(rst), .valid(dut.OUT_VALID), .i0(dut.FIRST_I_OUT),
		.i1(dut.FIRST_Q_OUT), .i2(dut.SECOND_I_OUT), .i3(dut.SECOND_Q_OUT),
		.s0(snk[0]), .s1(snk[1]), .s2(snk[2]), .s3(snk[3]), .cnt(cnt));

	// ---------------------------------------------------------------
	// expectations and bus tasks
	// ---------------------------------------------------------------
	function automatic logic [15:0] dbl(input logic [15:0] d);
		logic signed [16:0] t;
		t = $signed({d[15], d}) <<< 1;
		if (t > 17'sd32767) dbl = 16'h7fff;
		else if (t < -17'sd32768) dbl = 16'h8000;
		else dbl = t[15:0];
	endfunction
	function automatic logic [15:0] pat(input logic [3:0] c, input logic [15:0] d);
		case (c)
			4'h1: pat = 16'h0000;
			4'h2: pat = 16'hffff;
			4'h3: pat = ph ? 16'h5555 : 16'haaaa;
			4'h4: pat = rmp;
			4'h6: pat = 16'h1234;
			4'h7: pat = ph ? 16'h5678 : 16'h1234;
			4'h8: pat = 16'hffff;
			4'h9: pat = WORD_SYNC;
			default: pat = d;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	// one sample set; lanes are first i, first q, second i, second q
	task automatic smp(input logic [15:0] x, input logic [3:0] c0, c1, c2, c3, input logic g0, g1);
		logic [15:0] q;
		logic [15:0] e [4];
		q = x ^ 16'h0f0f;
		e[0] = pat(c0, g0 ? dbl(x) : x);
		e[1] = pat(c1, g0 ? dbl(q) : q);
		e[2] = pat(c2, g1 ? dbl(x) : x);
		e[3] = pat(c3, g1 ? dbl(q) : q);
		@(posedge clk);
		sv <= 1'b1;
		din <= '{x, q, x, q};
		@(posedge clk);
		sv <= 1'b0;
		@(posedge clk);
		#1;
		foreach (e[i]) `CHK(snk[i], e[i])
		rmp = rmp + 16'h0001;
		ph = ~ph;
		nsm++;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog and test sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		bad_count++;
		summarize;
	end
	initial begin
		{rst, we, re, wb, nb, sv, ph} = 7'b1000000;
		addr = 8'h00;
		wd = 8'h00;
		din = '{default: 16'h0000};
		rmp = 16'h0000;
		bad_count = 0;
		n_checks = 0;
		nsm = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i]) rdc(ra[i], 8'h00);
		wr(8'h20, 8'hff);
		rdc(8'h20, 8'h00);
		$display("test reset done");
		foreach (lc[i]) begin
			wr(8'h1e, lc[i]);
			`CHK(lat, lc[i][6:4])
			rdc(8'h1e, lc[i]);
		end
		foreach (uw[i]) wr(8'h33 + 8'(i), uw[i]);
		rdc(8'h36, uw[3]);
		foreach (uw[i]) rdc(8'h33 + 8'(i), uw[i]);
		$display("test registers done");
		wr(8'h38, 8'h11);
		for (int c = 0; c < 16; c++) begin
			wr(8'h37, {4'h2, c[3:0]});
			smp(16'h1234 + 16'(c), c[3:0], c[3:0], c[3:0], c[3:0], 1'b0, 1'b0);
		end
		wr(8'h37, 8'h43);
		wr(8'h38, 8'h76);
		wr(8'h39, 8'h01);
		repeat (3) smp(16'hbadc, 4'h3, 4'h4, 4'h6, 4'h7, 1'b0, 1'b0);
		// burst of four back-to-back samples: ramp and toggle advance every cycle
		@(posedge clk);
		sv <= 1'b1;
		repeat (4) @(posedge clk);
		sv <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(snk[1], rmp + 16'h0003)
		rmp = rmp + 16'h0004;
		nsm += 4;
		wr(8'h3a, 8'h03);
		smp(16'h0007, 4'h3, 4'h4, 4'h6, 4'h7, 1'b0, 1'b0);
		rdc(8'h3a, 8'h01);
		wr(8'h3a, 8'h03);
		rmp = 16'h0000;
		ph = 1'b0;
		smp(16'h0007, 4'h3, 4'h4, 4'h6, 4'h7, 1'b0, 1'b0);
		$display("test patterns done");
		wr(8'h39, 8'h00);
		wr(8'h37, 8'h00);
		wr(8'h1f, 8'h01);
		@(posedge clk);
		wb <= 1'b1;
		smp(16'h1000, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1);
		smp(16'ha000, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1);
		@(posedge clk);
		wb <= 1'b0;
		nb <= 1'b1;
		smp(16'h5000, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
		@(posedge clk);
		nb <= 1'b0;
		smp(16'h1000, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
		// wide path with narrowband gain requested but wideband bit clear: no gain
		wr(8'h1f, 8'h00);
		@(posedge clk);
		wb <= 1'b1;
		nb <= 1'b1;
		smp(16'h1000, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
		`CHK(cnt, nsm[15:0])
		$display("test gain done");
		summarize;
	end
endmodule
